// file: hw/ips_map.vh
// Purpose: Register map, field positions and reset values of the
//          interrupt priority stack.
// Assumes: Word addresses on the Y address bus, 16-bit Y data bus.
// Notes:   Register addresses are local choices inside the block window.
`ifndef IPS_MAP_VH
`define IPS_MAP_VH

`define IPS_ADDR_W 16
`define IPS_BASE 16'h0020
`define IPS_OFF_VECTOR0 16'h0000
`define IPS_OFF_MASK 16'h0008
`define IPS_OFF_PRIO 16'h0009
`define IPS_OFF_CTRL 16'h000A
`define IPS_OFF_DEPTH 16'h000B
`define IPS_OFF_PEND 16'h000C

`define IPS_PRIO_RST 16'h0000
`define IPS_CTRL_RST 16'h000B
`define IPS_MASK_RST 16'h5555
`define IPS_LVL_NONE 3'h7
`define IPS_LVL_TOP 3'h3
`define IPS_SLOT_EMPTY 3'h0
`define IPS_CTRL_EMPTY_BIT 3
`define IPS_CTRL_SLOT1_LSB 4
`define IPS_DEPTH_MAX 3'h4

`endif

// file: hw/ips_sync.v
// Purpose: Two-flop synchroniser for a bus of pin inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module ips_sync #(
   parameter W = 8
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b1}};
         q <= {W{1'b1}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// file: hw/ips_arbiter.v
// Purpose: Picks the highest-priority requesting source above a level.
// Assumes: Levels coded 111 for -1, 000..011 for 0..3.
// Notes:   Pure combinational; ties go to the lowest index.
`timescale 1ns/1ps
`include "ips_map.vh"
module ips_arbiter #(
   parameter N = 8
) (
   // Requests
   input wire [N-1:0] req,
   input wire [2*N-1:0] prio,
   input wire [2:0] level,
   // Result
   output reg win_valid,
   output reg [2:0] win_idx,
   output reg [1:0] win_prio
);
   integer i;
   // Level -1 accepts everything, so it compares as lowest
   function above;
      input [1:0] p;
      input [2:0] lvl;
      begin
         above = (lvl == `IPS_LVL_NONE) ? 1'b1 : ({1'b0, p} > lvl);
      end
   endfunction
   always @* begin
      win_valid = 1'b0;
      win_idx = 3'h0;
      win_prio = 2'h0;
      // Scan downward so a lower index wins an equal priority
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (req[i] && above(prio[2*i +: 2], level) &&
             (!win_valid || prio[2*i +: 2] >= win_prio)) begin // R2 R5
            win_valid = 1'b1;
            win_idx = i[2:0];
            win_prio = prio[2*i +: 2];
         end
      end
   end
endmodule

// file: hw/ips_top.v
// Functional notes
// R1: Every one of eight sources has a two-bit priority, 3 highest.
// R2: Equal priorities requesting together: smallest index served first.
// R3: Priority register packs source i in bits 2i+1..2i, resets zero.
// R4: Current level is three bits: 111 means -1, 000..011 are 0..3.
// R5: Request accepted only if its priority exceeds current level.
// R6: Acceptance pushes old level into slot one and raises level.
// R7: Four stacked slots; unused slots read 000.
// R8: Routine end pops the stack back into the current level.
// R9: Writing stacked slots alters the display, not the nesting.
// R10: Control register layout slots 4..1, empty flag, level; reset 000B.
// R11: Empty flag reads 1 with nothing stacked, 0 otherwise.
// R12: After reset level 3 blocks all sources until software lowers it.
// R13: Reserved bits read zero and ignore writes.
// R14: Depth register counts stacked levels; writes only alter display.
// R15: Pending flags bits 7..0, set on record, cleared on ack fall.
// R16: Software clearing a pending flag cancels that request.
// R17: Software setting a pending flag raises a request.
// R18: Software disables pending in core control, then clears all flags.
// R19: A set mask bit clears its pending flag; pending resets zero.
// R20: Serviced source vector driven on Y data after ack fall.
// R21: Core signals routine end on a dedicated input, popping.
// R22: Sensitivity 0 low level, 1 falling edge; masked inputs ignored.
// R23: Request output high while a pending source beats the level.
//
// Purpose: Priority, pending and level-stack section of an eight-source
//          interrupt controller on the core Y data bus.
// Assumes: Core strobes and ack are on clock; request lines are pins.
// Notes:   Y data is split into in, out and output enable.
`timescale 1ns/1ps
`include "ips_map.vh"
module ips_top #(
   parameter N = 8,
   parameter VEC_W = 16
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // External request lines, active low
   input wire [N-1:0] irq_input_line_n,
   // Core side
   output wire core_irq_output,
   input wire core_ack_input_n,
   input wire routine_done_input,
   // Y bus
   input wire [`IPS_ADDR_W-1:0] y_addr,
   input wire y_rd,
   input wire y_wr,
   input wire [15:0] y_data_in,
   output reg [15:0] y_data_out,
   output reg y_data_oe
);
   ////////////////////////////////////////////////////////////////////
   reg [VEC_W-1:0] vector_r [0:N-1];
   reg [15:0] mask_r;
   reg [2*N-1:0] source_priority_assign_r;
   reg [15:0] shown_ctrl_r;
   reg [2:0] shown_depth_r;
   reg [N-1:0] pending_request_status_r;
   reg [2:0] current_level_field_r;
   reg [11:0] stack_r;
   reg [2:0] depth_r;
   reg [N-1:0] line_prev_r;
   reg ack_prev_r;
   reg [2:0] serv_idx_r;
   reg [1:0] serv_prio_r;
   reg serv_valid_r;
   wire [N-1:0] line_s;
   wire [N-1:0] source_mask_bit;
   wire [N-1:0] source_sensitivity_bit;
   wire win_valid;
   wire [2:0] win_idx;
   wire [1:0] win_prio;
   wire ack_fall;
   wire do_push;
   wire do_pop;
   reg [N-1:0] detect;
   reg [N-1:0] pend_nxt;
   reg [15:0] ctrl_view;
   integer k;

   // Register select, shared by read and write decode
   function hit;
      input [`IPS_ADDR_W-1:0] a;
      input [`IPS_ADDR_W-1:0] off;
      begin
         hit = (a == (`IPS_BASE + off));
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; idle high since lines are active low
   ips_sync #(.W(N)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(irq_input_line_n),
      .q(line_s)
   );

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_bits
         assign source_mask_bit[g] = mask_r[2*g];
         assign source_sensitivity_bit[g] = mask_r[2*g+1];
      end
   endgenerate

   // Low level or falling edge, masked sources ignored
   always @* begin
      for (k = 0; k < N; k = k + 1) begin
         if (source_mask_bit[k])
            detect[k] = 1'b0; // R22
         else if (source_sensitivity_bit[k])
            detect[k] = line_prev_r[k] && !line_s[k]; // R22
         else
            detect[k] = !line_s[k]; // R22
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Arbitration over pending flags against the live level
   ips_arbiter #(.N(N)) u_arb (
      .req(pending_request_status_r & ~source_mask_bit),
      .prio(source_priority_assign_r), // R1
      .level(current_level_field_r), // R12
      .win_valid(win_valid),
      .win_idx(win_idx),
      .win_prio(win_prio)
   );

   assign core_irq_output = win_valid; // R23

   assign ack_fall = ack_prev_r && !core_ack_input_n;
   // Push on acknowledge of the source chosen while ack was high
   assign do_push = ack_fall && serv_valid_r &&
                    pending_request_status_r[serv_idx_r];
   // Pop only when something is stacked; push wins a clash
   assign do_pop = routine_done_input && !do_push &&
                   (depth_r != 3'h0); // R21

   ////////////////////////////////////////////////////////////////////
   // Pending flags: hardware set wins over any clear
   always @* begin
      pend_nxt = pending_request_status_r;
      if (y_wr && hit(y_addr, `IPS_OFF_PEND))
         pend_nxt = y_data_in[N-1:0]; // R16 R17
      if (do_push)
         pend_nxt[serv_idx_r] = 1'b0; // R15
      pend_nxt = pend_nxt | detect; // R15
      pend_nxt = pend_nxt & ~source_mask_bit; // R19
   end

   ////////////////////////////////////////////////////////////////////
   // Internal nesting stack; software can write only the current level
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         current_level_field_r <= `IPS_LVL_TOP; // R12
         stack_r <= 12'h000;
         depth_r <= 3'h0;
      end else if (do_push) begin
         stack_r <= {stack_r[8:0], current_level_field_r}; // R6
         current_level_field_r <= {1'b0, serv_prio_r}; // R6 R4
         if (depth_r != `IPS_DEPTH_MAX)
            depth_r <= depth_r + 3'h1;
      end else if (do_pop) begin
         current_level_field_r <= stack_r[2:0]; // R8
         stack_r <= {`IPS_SLOT_EMPTY, stack_r[11:3]}; // R8 R7
         depth_r <= depth_r - 3'h1;
      end else if (y_wr && hit(y_addr, `IPS_OFF_CTRL) &&
                   (y_data_in[2:0] <= `IPS_LVL_TOP ||
                    y_data_in[2:0] == `IPS_LVL_NONE)) begin
         // Software may lower the level; reserved codes are dropped
         current_level_field_r <= y_data_in[2:0]; // R12 R4
      end
   end

   // Displayed slots and depth: follow the stack, or software overlays
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shown_ctrl_r <= 16'h0000;
         shown_depth_r <= 3'h0;
      end else if (do_push || do_pop) begin
         shown_ctrl_r <= 16'h0000;
         shown_depth_r <= 3'h0;
      end else if (y_wr && hit(y_addr, `IPS_OFF_CTRL)) begin
         shown_ctrl_r <= {y_data_in[15:4], 4'h0} | 16'h0001; // R9
      end else if (y_wr && hit(y_addr, `IPS_OFF_DEPTH)) begin
         shown_depth_r <= y_data_in[2:0] | 3'h0; // R14
         shown_ctrl_r[0] <= 1'b1; // R14
         shown_ctrl_r[1] <= 1'b1;
      end
   end

   // Overlay bit 0 marks a software-written slot view
   always @* begin
      ctrl_view = 16'h0000;
      ctrl_view[15:`IPS_CTRL_SLOT1_LSB] = shown_ctrl_r[0] ?
         shown_ctrl_r[15:4] : stack_r; // R10 R7 R9
      ctrl_view[`IPS_CTRL_EMPTY_BIT] = (depth_r == 3'h0); // R11
      ctrl_view[2:0] = current_level_field_r; // R4 R10
   end

   ////////////////////////////////////////////////////////////////////
   // Software registers, ack tracking, vector table writes
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= `IPS_MASK_RST;
         source_priority_assign_r <= `IPS_PRIO_RST; // R3
         pending_request_status_r <= {N{1'b0}}; // R19
         line_prev_r <= {N{1'b1}};
         ack_prev_r <= 1'b1;
         serv_idx_r <= 3'h0;
         serv_prio_r <= 2'h0;
         serv_valid_r <= 1'b0;
         for (k = 0; k < N; k = k + 1)
            vector_r[k] <= {VEC_W{1'b0}};
      end else begin
         line_prev_r <= line_s;
         ack_prev_r <= core_ack_input_n;
         pending_request_status_r <= pend_nxt;
         if (core_ack_input_n) begin
            serv_idx_r <= win_idx;
            serv_prio_r <= win_prio;
            serv_valid_r <= win_valid;
         end
         if (y_wr && hit(y_addr, `IPS_OFF_MASK))
            mask_r <= y_data_in;
         if (y_wr && hit(y_addr, `IPS_OFF_PRIO))
            source_priority_assign_r <= y_data_in[2*N-1:0]; // R3
         for (k = 0; k < N; k = k + 1)
            if (y_wr && hit(y_addr, `IPS_OFF_VECTOR0 + k[15:0]))
               vector_r[k] <= y_data_in;
      end
   end

   // Read data and vector answer, registered
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         y_data_out <= 16'h0000;
         y_data_oe <= 1'b0;
      end else if (do_push) begin
         y_data_out <= vector_r[serv_idx_r]; // R20
         y_data_oe <= 1'b1; // R20
      end else if (y_rd) begin
         y_data_oe <= 1'b1;
         if (hit(y_addr, `IPS_OFF_PRIO))
            y_data_out <= source_priority_assign_r;
         else if (hit(y_addr, `IPS_OFF_CTRL))
            y_data_out <= ctrl_view;
         else if (hit(y_addr, `IPS_OFF_DEPTH))
            y_data_out <= {13'h0000, shown_depth_r | depth_r}; // R13 R14
         else if (hit(y_addr, `IPS_OFF_PEND))
            y_data_out <= {8'h00, pending_request_status_r}; // R13
         else if (hit(y_addr, `IPS_OFF_MASK))
            y_data_out <= mask_r;
         else if (y_addr >= `IPS_BASE &&
                  y_addr < `IPS_BASE + `IPS_OFF_MASK)
            y_data_out <= vector_r[y_addr[2:0]];
         else
            y_data_out <= 16'h0000;
      end else begin
         y_data_oe <= 1'b0;
      end
   end
endmodule

// file: tb/ips_checker.sv
// Purpose: Port-level checks of the interrupt priority stack.
// Assumes: One clock, rst_n asynchronous and active low.
// Notes: Bound to ips_top from the bench top file.
`timescale 1ns/1ps
`include "ips_map.vh"
module ips_checker #(
   parameter N = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pins and core link
   input wire logic [N-1:0] irq_input_line_n,
   input wire logic core_irq_output,
   input wire logic core_ack_input_n,
   input wire logic routine_done_input,
   // Y bus
   input wire logic [`IPS_ADDR_W-1:0] y_addr,
   input wire logic y_rd,
   input wire logic y_wr,
   input wire logic [15:0] y_data_in,
   input wire logic [15:0] y_data_out,
   input wire logic y_data_oe
);
default clocking cb @(posedge clock); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////
// Level 3 from reset holds until software writes the control word
logic lock_r;
always @(posedge clock or negedge rst_n) begin
   if (!rst_n)
      lock_r <= 1'b1;
   else if (y_wr && y_addr == `IPS_BASE + `IPS_OFF_CTRL)
      lock_r <= 1'b0;
end
sequence s_ack_fall;
   core_ack_input_n ##1 !core_ack_input_n;
endsequence
property p_rd_oe;
   y_rd && y_addr >= 16'h0020 && y_addr <= 16'h002C |=> y_data_oe;
endproperty
property p_quiet;
   !y_rd && !$fell(core_ack_input_n) |=> !y_data_oe;
endproperty
property p_unmapped;
   y_rd && y_addr == 16'h002F |=> !y_data_oe || y_data_out == 16'h0000;
endproperty
property p_depth_rsvd;
   y_rd && y_addr == 16'h002B |=> y_data_out[15:3] == 13'h0000;
endproperty
property p_pend_rsvd;
   y_rd && y_addr == 16'h002C |=> y_data_out[15:8] == 8'h00;
endproperty
property p_ctrl_code;
   y_rd && y_addr == 16'h002A |=>
      y_data_out[2:0] <= 3'h3 || y_data_out[2:0] == 3'h7;
endproperty
property p_ack_vec;
   s_ack_fall ##0 (core_irq_output && !y_rd) |=> y_data_oe;
endproperty
property p_lock;
   lock_r |-> !core_irq_output;
endproperty
a_rd_oe: assert property (p_rd_oe) else $error("no read answer");
a_quiet: assert property (p_quiet) else $error("stray answer");
a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
a_depth_rsvd: assert property (p_depth_rsvd) else $error("depth");
a_pend_rsvd: assert property (p_pend_rsvd) else $error("pending");
a_ctrl_code: assert property (p_ctrl_code) else $error("level code");
a_ack_vec: assert property (p_ack_vec) else $error("no vector");
a_lock: assert property (p_lock) else $error("request at reset");
endmodule

// file: tb/ips_core_model.sv
// Purpose: Core side of the ack link, answers the request output.
// Assumes: Driven on the falling clock edge.
// Notes: slow adds three cycles before the ack.
`timescale 1ns/1ps
module ips_core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Bench control
   input wire logic en,
   input wire logic slow,
   input wire logic done_req,
   // Core pins
   input wire logic core_irq_output,
   output logic core_ack_input_n,
   output wire logic routine_done_input
);
logic [2:0] cnt_r;
// Routine end comes on its own input, one cycle high
assign routine_done_input = done_req;
// Rest time after each ack lets pending and level settle first
always @(negedge clock or negedge rst_n) begin
   if (!rst_n) begin
      cnt_r <= 3'h0;
      core_ack_input_n <= 1'b1;
   end else begin
      core_ack_input_n <= (cnt_r != 3'h2);
      if (cnt_r != 3'h0)
         cnt_r <= cnt_r - 3'h1;
      else if (en && core_irq_output)
         cnt_r <= slow ? 3'h7 : 3'h4;
   end
end
endmodule

// file: tb/ips_top_tb.sv
// Purpose: Register and ack-link tests of the priority stack.
// Assumes: Inputs change on the falling edge.
// Notes: Expected words are worked out by hand from the layout.
`timescale 1ns/1ps
`include "ips_map.vh"
module ips_top_tb;
logic clock = 1'b0;
logic rst_n = 1'b0;
logic [7:0] irq_input_line_n = 8'hFF;
logic y_rd = 1'b0;
logic y_wr = 1'b0;
logic [15:0] y_addr = 16'h0000;
logic [15:0] y_data_in = 16'h0000;
logic en = 1'b0;
logic slow = 1'b0;
logic done_req = 1'b0;
wire core_irq_output, core_ack_input_n, routine_done_input, y_data_oe;
wire [15:0] y_data_out;
int n_mismatch = 0;
int compares = 0;
logic [15:0] ce [0:4] = '{16'h000F, 16'h0070, 16'h0381, 16'h1C12, 16'hE0A3};
always #5 clock = ~clock;
ips_top dut (.clock(clock), .rst_n(rst_n),
   .irq_input_line_n(irq_input_line_n), .core_irq_output(core_irq_output),
   .core_ack_input_n(core_ack_input_n),
   .routine_done_input(routine_done_input), .y_addr(y_addr), .y_rd(y_rd),
   .y_wr(y_wr), .y_data_in(y_data_in), .y_data_out(y_data_out),
   .y_data_oe(y_data_oe));
ips_core_model core (.clock(clock), .rst_n(rst_n), .en(en), .slow(slow),
   .done_req(done_req), .core_irq_output(core_irq_output),
   .core_ack_input_n(core_ack_input_n),
   .routine_done_input(routine_done_input));
////////////////////////////////////////////////////////////////////////
task close_out;
   $display("compares %0d mismatches %0d", compares, n_mismatch);
   if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
   else
      $display("STATUS NOT OK");
   $finish;
endtask
task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
   compares++;
   if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
   end
endtask
task wr(input logic [15:0] off, input logic [15:0] d);
   @(negedge clock);
   y_addr = `IPS_BASE + off;
   y_data_in = d;
   y_wr = 1'b1;
   @(negedge clock);
   y_wr = 1'b0;
endtask
task rd(input logic [15:0] off, input logic [15:0] exp);
   @(negedge clock);
   y_addr = `IPS_BASE + off;
   y_rd = 1'b1;
   @(negedge clock);
   y_rd = 1'b0;
   chk("read oe", {15'h0000, y_data_oe}, 16'h0001);
   chk("read data", y_data_out, exp);
endtask
task wait_vec(input logic [15:0] exp);
   int k;
   en = 1'b1;
   for (k = 0; k < 30 && y_data_oe !== 1'b1; k++)
      @(negedge clock);
   en = 1'b0;
   if (k == 30) begin
      n_mismatch++;
      close_out;
   end
   chk("vector", y_data_out, exp);
endtask
task done;
   @(negedge clock);
   done_req = 1'b1;
   @(negedge clock);
   done_req = 1'b0;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
   int i;
   repeat (5) @(negedge clock);
   rst_n = 1'b1;
   rd(`IPS_OFF_CTRL, `IPS_CTRL_RST);
   rd(`IPS_OFF_DEPTH, 16'h0000);
   rd(`IPS_OFF_PEND, 16'h0000);
   rd(`IPS_OFF_PRIO, `IPS_PRIO_RST);
   rd(16'h000F, 16'h0000);
   // Source 1 stays masked while both pins go low
   wr(`IPS_OFF_MASK, 16'h0004);
   @(negedge clock);
   irq_input_line_n = 8'hFC;
   repeat (4) @(negedge clock);
   irq_input_line_n = 8'hFF;
   repeat (4) @(negedge clock);
   rd(`IPS_OFF_PEND, 16'h0001);
   chk("irq", {15'h0000, core_irq_output}, 16'h0000);
   wr(`IPS_OFF_MASK, 16'h0005);
   rd(`IPS_OFF_PEND, 16'h0000);
   // Source 0 on falling edge: a held-low line records only once
   wr(`IPS_OFF_MASK, 16'h0002);
   irq_input_line_n = 8'hFE;
   repeat (4) @(negedge clock);
   rd(`IPS_OFF_PEND, 16'h0001);
   wr(`IPS_OFF_PEND, 16'h0000);
   rd(`IPS_OFF_PEND, 16'h0000);
   irq_input_line_n = 8'hFF;
   repeat (4) @(negedge clock);
   wr(`IPS_OFF_MASK, 16'h0000);
   wr(`IPS_OFF_PRIO, 16'h02E4);
   rd(`IPS_OFF_PRIO, 16'h02E4);
   for (i = 0; i < 8; i++)
      wr(`IPS_OFF_VECTOR0 + 16'(i), 16'hA000 + 16'(i));
   wr(`IPS_OFF_PEND, 16'hFF00);
   rd(`IPS_OFF_PEND, 16'h0000);
   wr(`IPS_OFF_CTRL, 16'h0007);
   for (i = 0; i < 4; i++) begin
      wr(`IPS_OFF_PEND, 16'h0001 << i);
      chk("irq", {15'h0000, core_irq_output}, 16'h0001);
      slow = i[0];
      wait_vec(16'hA000 + 16'(i));
      rd(`IPS_OFF_CTRL, ce[i+1]);
      rd(`IPS_OFF_DEPTH, 16'(i + 1));
   end
   for (i = 4; i > 0; i--) begin
      done;
      rd(`IPS_OFF_CTRL, ce[i-1]);
      rd(`IPS_OFF_DEPTH, 16'(i - 1));
   end
   wr(`IPS_OFF_PEND, 16'h0014);
   wait_vec(16'hA002);
   rd(`IPS_OFF_PEND, 16'h0010);
   chk("irq", {15'h0000, core_irq_output}, 16'h0000);
   wr(`IPS_OFF_PEND, 16'h0000);
   done;
   chk("irq", {15'h0000, core_irq_output}, 16'h0000);
   // Slot and depth writes alter the view only; reserved level ignored
   wr(`IPS_OFF_CTRL, 16'hFFF7);
   rd(`IPS_OFF_CTRL, 16'hFFFF);
   wr(`IPS_OFF_CTRL, 16'h0004);
   rd(`IPS_OFF_CTRL, 16'h000F);
   wr(`IPS_OFF_DEPTH, 16'hFFFF);
   rd(`IPS_OFF_DEPTH, 16'h0007);
   rd(`IPS_OFF_CTRL, 16'h000F);
   close_out;
end
endmodule
bind ips_top ips_checker #(.N(N)) chk_i (.clock(clock), .rst_n(rst_n),
   .irq_input_line_n(irq_input_line_n), .core_irq_output(core_irq_output),
   .core_ack_input_n(core_ack_input_n),
   .routine_done_input(routine_done_input), .y_addr(y_addr), .y_rd(y_rd),
   .y_wr(y_wr), .y_data_in(y_data_in), .y_data_out(y_data_out),
   .y_data_oe(y_data_oe));
